//--- rtl/asrr_regs.sv
// serial-bus slave with the own-address select and soft reset registers
// Functional notes
// - address register holds strap address after reset
// - bit 0 selects strap or software address
// - bit 4 pulses video-input reset, self-clears
// - bit 1 pulses full reset including registers
// - bit 0 pulses logic reset sparing registers
// - register-sparing reset reloads strap-derived values
// - register-sparing reset restores listed register defaults
// - acknowledge matching address, otherwise release line
`timescale 1ns/100ps
`include "asrr_params.svh"

module asrr_regs
  import asrr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [2:0] address_strap_pin_i,
  output logic [6:0]      own_bus_address_o,
  output logic            video_in_rst_o,
  output logic            full_digital_clear_o,
  output logic            logic_clear_keep_regs_o,
  output logic            restore_defaults_o
);

  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic [2:0]  strap_s1_reg;
  logic [2:0]  strap_s2_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  asrr_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic        rw_reg;
  logic        got_ptr_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  tx_reg;
  logic        drive_reg;
  logic        wr_stb_reg;
  logic [7:0]  wr_ptr_reg;
  logic [7:0]  wr_data_reg;
  logic [6:0]  strap_addr_reg;
  logic [7:0]  addr_sel_reg;
  logic        video_rst_reg;
  logic        full_clear_reg;
  logic        keep_clear_reg;
  logic        reg_reload;
  logic [6:0]  strap_decoded;
  logic        addr_match;
  logic [7:0]  rd_word;

  // pins come from outside: two flip-flops before any use
  always_ff @(posedge sys_clk_i) begin
    scl_sync_reg <= {scl_sync_reg[0], scl_i};
    sda_sync_reg <= {sda_sync_reg[0], sda_i};
    strap_s1_reg <= address_strap_pin_i;
    strap_s2_reg <= strap_s1_reg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  assign scl_rise   = scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall   = ~scl_sync_reg[1] & scl_prev_reg;
  assign start_cond = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
  assign stop_cond  = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];

  // strap levels step the address by two from the base
  assign strap_decoded = `ASRR_STRAP_BASE_ADDR + {3'h0, strap_s2_reg, 1'b0};

  assign own_bus_address_o = addr_sel_reg[`ASRR_ADDR_SEL_BIT] ? addr_sel_reg[7:1]
                                                              : strap_addr_reg;
  assign addr_match        = (shift_reg[7:1] == own_bus_address_o);

  // full clear restores registers as well; keep-regs clear only the listed ones
  assign reg_reload = sys_rst_i | full_clear_reg | keep_clear_reg;

  always_ff @(posedge sys_clk_i) begin
    if (reg_reload) begin
      strap_addr_reg <= strap_decoded;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reg_reload) begin
      addr_sel_reg <= {strap_decoded, `ASRR_ADDR_SEL_RST_LSB};
    end else if (wr_stb_reg && wr_ptr_reg == `ASRR_OFF_ADDR_SEL) begin
      addr_sel_reg <= wr_data_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || full_clear_reg) begin
      video_rst_reg  <= 1'b0;
      full_clear_reg <= 1'b0;
      keep_clear_reg <= 1'b0;
    end else begin
      video_rst_reg  <= wr_stb_reg && wr_ptr_reg == `ASRR_OFF_SOFT_RST
                        && wr_data_reg[`ASRR_VIDEO_RST_BIT];
      full_clear_reg <= wr_stb_reg && wr_ptr_reg == `ASRR_OFF_SOFT_RST
                        && wr_data_reg[`ASRR_FULL_CLEAR_BIT];
      keep_clear_reg <= wr_stb_reg && wr_ptr_reg == `ASRR_OFF_SOFT_RST
                        && wr_data_reg[`ASRR_KEEP_CLEAR_BIT];
    end
  end

  assign video_in_rst_o          = video_rst_reg;
  assign full_digital_clear_o    = full_clear_reg;
  assign logic_clear_keep_regs_o = keep_clear_reg;
  // listed registers elsewhere restore with it
  assign restore_defaults_o      = keep_clear_reg;

  // soft reset register always reads zero
  function automatic logic [7:0] read_mux(input logic [7:0] ptr);
    read_mux = (ptr == `ASRR_OFF_ADDR_SEL) ? addr_sel_reg : `ASRR_SOFT_RST_RESET;
  endfunction

  // a call result cannot be bit-selected, so the read word is a net
  assign rd_word = read_mux(ptr_reg);

  // bus engine is spared by soft clears so the command byte still gets its ack
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_reg   <= ST_IDLE;
      shift_reg   <= 8'h00;
      bit_cnt_reg <= 4'h0;
      rw_reg      <= 1'b0;
      got_ptr_reg <= 1'b0;
      ptr_reg     <= 8'h00;
      tx_reg      <= 8'h00;
      drive_reg   <= 1'b0;
      wr_stb_reg  <= 1'b0;
      wr_ptr_reg  <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (start_cond) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        drive_reg   <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        drive_reg <= 1'b0;
      end else if (scl_rise) begin
        shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (scl_fall) begin
        unique case (state_reg)
          ST_IDLE: begin
            drive_reg <= 1'b0;
          end
          ST_ADDR: begin
            if (bit_cnt_reg == `ASRR_BYTE_BITS) begin
              if (addr_match) begin
                state_reg <= ST_ACK_A;
                drive_reg <= 1'b1;
                rw_reg    <= shift_reg[0];
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK_A: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_TX;
              tx_reg    <= rd_word;
              drive_reg <= ~rd_word[7];
            end else begin
              state_reg   <= ST_RX;
              got_ptr_reg <= 1'b0;
              drive_reg   <= 1'b0;
            end
          end
          ST_RX: begin
            if (bit_cnt_reg == `ASRR_BYTE_BITS) begin
              state_reg <= ST_ACK_W;
              drive_reg <= 1'b1;
              if (!got_ptr_reg) begin
                ptr_reg     <= shift_reg;
                got_ptr_reg <= 1'b1;
              end else begin
                wr_stb_reg  <= 1'b1;
                wr_ptr_reg  <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg     <= ptr_reg + 8'h01;
              end
            end
          end
          ST_ACK_W: begin
            state_reg   <= ST_RX;
            bit_cnt_reg <= 4'h0;
            drive_reg   <= 1'b0;
          end
          ST_TX: begin
            if (bit_cnt_reg == `ASRR_BYTE_BITS) begin
              state_reg <= ST_RACK;
              drive_reg <= 1'b0;
              ptr_reg   <= ptr_reg + 8'h01;
            end else begin
              tx_reg    <= {tx_reg[6:0], 1'b0};
              drive_reg <= ~tx_reg[6];
            end
          end
          ST_RACK: begin
            // master nack ends the read
            bit_cnt_reg <= 4'h0;
            if (!shift_reg[0]) begin
              state_reg <= ST_TX;
              tx_reg    <= rd_word;
              drive_reg <= ~rd_word[7];
            end else begin
              state_reg <= ST_IDLE;
              drive_reg <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_reg;

  sequence soft_wr_s(int b);
    wr_stb_reg && wr_ptr_reg == `ASRR_OFF_SOFT_RST && wr_data_reg[b];
  endsequence

  sequence addr_byte_done_s;
    scl_fall && !start_cond && !stop_cond && state_reg == ST_ADDR
      && bit_cnt_reg == `ASRR_BYTE_BITS;
  endsequence

  strap_default_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(sys_rst_i) |-> addr_sel_reg == {strap_addr_reg, 1'b0})
    else $error("address register not strap after reset");
  sw_addr_sel_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_stb_reg && wr_ptr_reg == `ASRR_OFF_ADDR_SEL && wr_data_reg[0]
      |=> own_bus_address_o == $past(wr_data_reg[7:1]))
    else $error("software address not selected");
  video_pulse_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_wr_s(`ASRR_VIDEO_RST_BIT) |=> video_in_rst_o ##1 !video_in_rst_o)
    else $error("video reset pulse wrong");
  full_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_wr_s(`ASRR_FULL_CLEAR_BIT) |=> full_digital_clear_o ##1
      (!full_digital_clear_o && addr_sel_reg[0] == 1'b0))
    else $error("full clear pulse or register reset wrong");
  keep_clear_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_wr_s(`ASRR_KEEP_CLEAR_BIT) |=> logic_clear_keep_regs_o ##1
      !logic_clear_keep_regs_o)
    else $error("keep-regs clear pulse wrong");
  strap_reload_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    logic_clear_keep_regs_o |=> addr_sel_reg == {strap_addr_reg, 1'b0})
    else $error("strap value not reloaded");
  restore_list_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    soft_wr_s(`ASRR_KEEP_CLEAR_BIT) |=> restore_defaults_o)
    else $error("restore defaults not pulsed");
  addr_ack_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    addr_byte_done_s |=> (sda_oe_o == $past(addr_match)))
    else $error("address ack does not follow match");
  soft_read_zero_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    scl_fall && !start_cond && !stop_cond && state_reg == ST_ACK_A && rw_reg
      && ptr_reg == `ASRR_OFF_SOFT_RST |=> tx_reg == 8'h00)
    else $error("soft reset register reads nonzero");

endmodule

//--- rtl/asrr_params.svh
// offsets, field positions and reset values of the address and soft reset registers
`ifndef ASRR_PARAMS_SVH
`define ASRR_PARAMS_SVH

`define ASRR_OFF_ADDR_SEL     8'h00
`define ASRR_OFF_SOFT_RST     8'h01
`define ASRR_ADDR_SEL_BIT     0
`define ASRR_VIDEO_RST_BIT    4
`define ASRR_FULL_CLEAR_BIT   1
`define ASRR_KEEP_CLEAR_BIT   0
`define ASRR_ADDR_SEL_RST_LSB 1'h0
`define ASRR_SOFT_RST_RESET   8'h00
`define ASRR_STRAP_BASE_ADDR  7'h0C
`define ASRR_BYTE_BITS        4'h8

`endif

//--- rtl/asrr_pkg.sv
// types of the address and soft reset register block
package asrr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_A,
    ST_RX,
    ST_ACK_W,
    ST_TX,
    ST_RACK
  } asrr_state_t;

endpackage

//--- tb/asrr_i2c_host.sv
// i2c host controller model on the serial control pins
`timescale 1ns/100ps
module asrr_i2c_host (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // phases of 8 clocks, twice the slave minimum
  task automatic half();
    repeat (8) @(negedge sys_clk_i);
  endtask
  // also serves as repeated start
  task automatic start();
    sda_low_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_low_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_low_o = 1'b0;
    half();
  endtask
  // sample late in the high phase, well after the slave answer settles
  task automatic clk_bit(input logic b, output logic s);
    sda_low_o = !b;
    half();
    scl_o = 1'b1;
    half();
    s = sda_i;
    scl_o = 1'b0;
    // data hold after the clock falls, so no false start or stop is seen
    repeat (2) @(negedge sys_clk_i);
  endtask
  // ninth bit always released: no ack on writes, nack ends reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask
endmodule

//--- tb/asrr_regs_bench.sv
// self-checking bench of the address select and soft reset registers
`timescale 1ns/100ps
`include "asrr_params.svh"
module asrr_regs_bench;
  logic       sys_clk_i, sys_rst_i, scl, sda_low, sda_o, sda_oe_o, sda, ack;
  logic       vid, full, keep, rest;
  logic [2:0] strap;
  logic [6:0] own_addr, strap_addr, new_a;
  logic [7:0] model_reg0, q;
  logic [7:0] cmds [4] = '{8'h10, 8'h01, 8'h02, 8'hEC};
  int         err_count = 0, checked = 0, cycles = 0, seed = 89760;
  int         n_vid = 0, n_full = 0, n_keep = 0, n_rest = 0, e_vid = 0, e_full = 0, e_keep = 0;
  // pull-up: released line reads high
  assign sda = (sda_low | (sda_oe_o & ~sda_o)) ? 1'b0 : 1'b1;
  asrr_regs i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .address_strap_pin_i(strap),
    .own_bus_address_o(own_addr), .video_in_rst_o(vid), .full_digital_clear_o(full),
    .logic_clear_keep_regs_o(keep), .restore_defaults_o(rest));
  asrr_i2c_host i_host (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    n_vid <= n_vid + (vid === 1'b1);
    n_full <= n_full + (full === 1'b1);
    n_keep <= n_keep + (keep === 1'b1);
    n_rest <= n_rest + (rest === 1'b1);
    if (cycles == 60000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_bit(string n, logic e, logic s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chk_byte(string n, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] off, logic [7:0] d, logic e);
    i_host.start();
    i_host.xfer({a, 1'b0}, q, ack);
    chk_bit("address ack", e, ack);
    i_host.xfer(off, q, ack);
    chk_bit("offset ack", e, ack);
    i_host.xfer(d, q, ack);
    chk_bit("data ack", e, ack);
    i_host.stop();
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] off, output logic [7:0] d);
    wr_ptr: begin
      i_host.start();
      i_host.xfer({a, 1'b0}, q, ack);
      i_host.xfer(off, q, ack);
      i_host.start();
      i_host.xfer({a, 1'b1}, q, ack);
      chk_bit("read address ack", 1'b1, ack);
      i_host.xfer(8'hFF, d, ack);
      i_host.stop();
    end
  endtask
  task automatic chk_state();
    chk_byte("own address", {1'b0, model_reg0[7:1]}, {1'b0, own_addr});
    rd(model_reg0[7:1], `ASRR_OFF_ADDR_SEL, q);
    chk_byte("address register", model_reg0, q);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    strap = 3'($random(seed));
    strap_addr = `ASRR_STRAP_BASE_ADDR + {3'h0, strap, 1'b0};
    model_reg0 = {strap_addr, 1'b0};
    new_a = 7'h40 | 7'($random(seed) & 32'h3F);
    repeat (20) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk_state();
    wr(strap_addr + 7'h01, `ASRR_OFF_ADDR_SEL, 8'hFF, 1'b0);
    chk_state();
    foreach (cmds[i]) begin
      wr(model_reg0[7:1], `ASRR_OFF_ADDR_SEL, {new_a, 1'b1}, 1'b1);
      model_reg0 = {new_a, 1'b1};
      chk_state();
      wr(strap_addr, `ASRR_OFF_SOFT_RST, 8'h00, 1'b0);
      wr(new_a, `ASRR_OFF_SOFT_RST, cmds[i], 1'b1);
      if (cmds[i][0] | cmds[i][1]) model_reg0 = {strap_addr, 1'b0};
      e_vid += cmds[i][4];
      e_full += cmds[i][1];
      e_keep += cmds[i][0];
      chk_byte("video reset pulses", 8'(e_vid), 8'(n_vid));
      chk_byte("full clear pulses", 8'(e_full), 8'(n_full));
      chk_byte("keep clear pulses", 8'(e_keep), 8'(n_keep));
      chk_byte("restore pulses", 8'(e_keep), 8'(n_rest));
      chk_state();
      if (cmds[i][1]) wr(strap_addr, 8'h4F, 8'h02, 1'b1);
      rd(model_reg0[7:1], `ASRR_OFF_SOFT_RST, q);
      chk_byte("reset register", `ASRR_SOFT_RST_RESET, q);
    end
    close_out();
  end
endmodule
